// ---- mdipc_pkg.sv ----
/*
 Constants, field positions, reset values and carrier types of the
 motion detect, interrupt and power control block.
 Assumes a single 100 MHz clock domain for the block's own logic.
*/
package mdipc_pkg;
	localparam logic [5:0] ADDR_ID        = 6'h00;
	localparam logic [5:0] ADDR_QUIET_DUR = 6'h26;
	localparam logic [5:0] ADDR_AXIS_CTL  = 6'h27;
	localparam logic [5:0] ADDR_RATE      = 6'h2c;
	localparam logic [5:0] ADDR_POWER     = 6'h2d;
	localparam logic [5:0] ADDR_IRQ_EN    = 6'h2e;
	localparam logic [5:0] ADDR_IRQ_SEL   = 6'h2f;
	localparam logic [5:0] ADDR_FLAGS     = 6'h30;
	localparam logic [5:0] ADDR_FORMAT    = 6'h31;
	localparam logic [5:0] ADDR_DATA_LO   = 6'h32;
	localparam logic [5:0] ADDR_DATA_HI   = 6'h37;
	localparam logic [7:0] RST_RATE       = 8'h0a;
	localparam logic [7:0] RST_FLAGS      = 8'h02;
	localparam logic [7:0] MASK_RATE      = 8'h1f;
	localparam logic [7:0] MASK_POWER     = 8'h3f;
	localparam logic [7:0] MASK_IRQ       = 8'h9b;
	localparam logic [7:0] MASK_FORMAT    = 8'hef;
	localparam logic [7:0] MASK_FIFO_FLAG = 8'h83;
	localparam logic [7:0] MASK_MOT_FLAG  = 8'h18;
	localparam int BIT_ACT_AC   = 7;
	localparam int BIT_ACT_X    = 6;
	localparam int BIT_QUIET_AC = 3;
	localparam int BIT_QUIET_X  = 2;
	localparam int BIT_LOWPWR   = 4;
	localparam int BIT_LINK     = 5;
	localparam int BIT_AUTO     = 4;
	localparam int BIT_MEASURE  = 3;
	localparam int BIT_SLEEP    = 2;
	localparam int BIT_DREADY   = 7;
	localparam int BIT_ACT      = 4;
	localparam int BIT_QUIET    = 3;
	localparam int BIT_WMARK    = 1;
	localparam int BIT_OVR      = 0;
	localparam int BIT_SELFTEST = 7;
	localparam int BIT_3WIRE    = 6;
	localparam int BIT_INVERT   = 5;
	localparam int BIT_FULLRES  = 3;
	localparam int BIT_JUSTIFY  = 2;
	localparam int SPI_RW_BIT   = 7;
	localparam int QUIET_LSB_S   = 1;
	localparam int CLK_FREQ_HZ   = 100000000;
	localparam int QUIET_LSB_CYC = QUIET_LSB_S * CLK_FREQ_HZ;
	typedef struct packed {
		logic [2:0][15:0] axis;
	} mdipc_sample_type;
	typedef struct packed {
		logic       rd;
		logic       mb;
		logic [5:0] addr;
	} mdipc_cmd_type;
	typedef enum logic {LINK_SEEK_QUIET, LINK_SEEK_MOTION} mdipc_link_type;
endpackage

// ---- mdipc_top.sv ----
/*
 Motion detect, interrupt and power control with its SPI register port.
 Assumes samples arrive on clk_in at 2.9 mg per count, sign in bit 15,
 and that FIFO events are one-cycle pulses on clk_in.
*/
`timescale 1ns/1ns
`default_nettype none
module mdipc_top
	import mdipc_pkg::*;
#(
	parameter int unsigned CYC_PER_SEC = QUIET_LSB_CYC,
	parameter logic [7:0]  DEV_ID      = 8'h5a
) (
	input  wire logic        clk_in,               // 100 MHz clock
	input  wire logic        rst_in,               // async reset, high
	input  wire logic        ce_in,                // clock enable
	input  wire logic        spi_cs_n_in,          // chip select, low
	input  wire logic        spi_sclk_in,          // serial clock
	input  wire logic        spi_sdi_in,           // 4-wire data in
	input  wire logic        spi_sdio_in,          // 3-wire data in
	output logic             spi_sdo_out,          // data out
	output logic             spi_sdo_oe_n_out,     // drive enable, low
	input  wire logic        sample_valid_in,      // new sample pulse
	input  wire mdipc_sample_type sample_in,       // x, y, z samples
	input  wire logic [7:0]  motion_threshold_in,  // motion threshold
	input  wire logic [7:0]  quiet_threshold_in,   // quiet threshold
	input  wire logic        dready_event_in,      // data ready pulse
	input  wire logic        watermark_event_in,   // watermark pulse
	input  wire logic        overrun_event_in,     // overrun pulse
	output logic             irq_line_a_out,       // interrupt line a
	output logic             irq_line_b_out,       // interrupt line b
	output logic             measure_out,          // measurement mode
	output logic             sleep_out,            // sleeping
	output logic             fifo_write_en_out,    // FIFO may take data
	output logic             data_read_out,        // axis data read pulse
	output logic             low_power_out,        // reduced power
	output logic [3:0]       sample_rate_out,      // rate code
	output logic [1:0]       doze_reading_rate_out, // sleep rate code
	output logic             self_test_out,        // test force on
	output logic             three_wire_out,       // 3-wire SPI
	output logic             scaled_resolution_mode_out, // scaled res
	output logic             justify_out,          // left justify
	output logic [1:0]       range_out             // g range code
);
	logic [7:0]       dur_q, axis_q, rate_q, power_q;
	logic [7:0]       en_q, sel_q, fmt_q, flags_q, rpt_q;
	logic [2:0]       sync1_q, sync2_q, sync3_q, pin_q;
	logic             sclk_prev_q, cmd_done_q, doze_q;
	logic [2:0]       bit_cnt_q;
	logic [6:0]       shift_q;
	logic [7:0]       tx_q;
	mdipc_cmd_type    cmd_q;
	mdipc_sample_type data_q;
	mdipc_link_type   st_q;
	logic             aref_ok_q, qref_ok_q, q_arm_q, q_fired_q;
	logic [31:0]      tick_q;
	logic [7:0]       secs_q;
	logic             irq_a_q, irq_b_q, sdo_q, oe_n_q;
	logic             fifo_wr_q, sleep_q, data_rd_q;
	logic [2:0]       act_hit_w, q_hit_w;

	// pins pass three flops; a level is taken once stages two and three agree
	wire logic [2:0] pin_raw_w = {spi_cs_n_in, spi_sclk_in,
		fmt_q[BIT_3WIRE] ? spi_sdio_in : spi_sdi_in};
	wire logic [2:0] agree_w = ~(sync2_q ^ sync3_q);
	wire logic [2:0] pin_d = (sync2_q & agree_w) | (pin_q & ~agree_w);
	wire logic cs_n_w = pin_q[2];
	wire logic rise_w = pin_q[1] & ~sclk_prev_q & ~cs_n_w;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_q <= 3'h7;
			sync2_q <= 3'h7;
			sync3_q <= 3'h7;
			pin_q <= 3'h7;
			sclk_prev_q <= 1'b1;
		end else if (ce_in) begin
			sync1_q <= pin_raw_w;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pin_q <= pin_d;
			sclk_prev_q <= pin_q[1];
		end
	end

	// serial framing: command byte, then data bytes, MSB first
	wire logic [7:0] byte_w = {shift_q, pin_q[0]};
	wire logic byte_end_w = rise_w && (bit_cnt_q == 3'h7);
	wire logic [5:0] nxt_addr_w = cmd_q.mb ? 6'(cmd_q.addr + 6'h01)
		: cmd_q.addr;
	wire logic [5:0] acc_addr_w = cmd_done_q ? nxt_addr_w : byte_w[5:0];
	wire logic rd_load_w = byte_end_w
		&& (cmd_done_q ? cmd_q.rd : byte_w[SPI_RW_BIT]);
	wire logic wr_w = byte_end_w && cmd_done_q && !cmd_q.rd;
	wire logic rd_done_w = byte_end_w && cmd_done_q && cmd_q.rd;
	// side effects act only once a read byte has gone out in full
	wire logic flag_rd_w = rd_done_w && (cmd_q.addr == ADDR_FLAGS);
	wire logic data_rd_w = rd_done_w && (cmd_q.addr >= ADDR_DATA_LO)
		&& (cmd_q.addr <= ADDR_DATA_HI);
	wire logic [2:0] didx_w = 3'(acc_addr_w - ADDR_DATA_LO);
	wire logic [15:0] dword_w = data_q.axis[didx_w[2:1]];
	wire logic in_data_w = (acc_addr_w >= ADDR_DATA_LO)
		&& (acc_addr_w <= ADDR_DATA_HI);
	wire logic [7:0] rd_data_w =
		(acc_addr_w == ADDR_ID)        ? DEV_ID :
		(acc_addr_w == ADDR_QUIET_DUR) ? dur_q :
		(acc_addr_w == ADDR_AXIS_CTL)  ? axis_q :
		(acc_addr_w == ADDR_RATE)      ? rate_q :
		(acc_addr_w == ADDR_POWER)     ? power_q :
		(acc_addr_w == ADDR_IRQ_EN)    ? en_q :
		(acc_addr_w == ADDR_IRQ_SEL)   ? sel_q :
		(acc_addr_w == ADDR_FLAGS)     ? flags_q :
		(acc_addr_w == ADDR_FORMAT)    ? fmt_q :
		!in_data_w                     ? 8'h00 :
		didx_w[0]                      ? dword_w[15:8] : dword_w[7:0];

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			bit_cnt_q <= 3'h0;
			shift_q <= 7'h00;
			cmd_done_q <= 1'b0;
			cmd_q <= '0;
			tx_q <= 8'h00;
			rpt_q <= 8'h00;
			sdo_q <= 1'b0;
			oe_n_q <= 1'b1;
		end else if (ce_in) begin
			if (cs_n_w) begin
				bit_cnt_q <= 3'h0;
				cmd_done_q <= 1'b0;
				oe_n_q <= 1'b1;
			end else if (rise_w) begin
				bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
				shift_q <= byte_w[6:0];
				if (byte_end_w) begin
					cmd_done_q <= 1'b1;
					if (!cmd_done_q)
						cmd_q <= mdipc_cmd_type'(byte_w);
					else
						cmd_q.addr <= nxt_addr_w;
					if (rd_load_w) begin
						tx_q <= rd_data_w;
						rpt_q <= rd_data_w;
						sdo_q <= rd_data_w[7];
						oe_n_q <= 1'b0;
					end
				end else if (!oe_n_q) begin
					tx_q <= {tx_q[6:0], 1'b0};
					sdo_q <= tx_q[6];
				end
			end
		end
	end

	// register writes; fixed zero fields are masked off
	wire logic we_dur_w  = wr_w && (cmd_q.addr == ADDR_QUIET_DUR);
	wire logic we_axis_w = wr_w && (cmd_q.addr == ADDR_AXIS_CTL);
	wire logic we_rate_w = wr_w && (cmd_q.addr == ADDR_RATE);
	wire logic we_pwr_w  = wr_w && (cmd_q.addr == ADDR_POWER);
	wire logic we_en_w   = wr_w && (cmd_q.addr == ADDR_IRQ_EN);
	wire logic we_sel_w  = wr_w && (cmd_q.addr == ADDR_IRQ_SEL);
	wire logic we_fmt_w  = wr_w && (cmd_q.addr == ADDR_FORMAT);

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dur_q <= 8'h00;
			axis_q <= 8'h00;
			rate_q <= RST_RATE;
			power_q <= 8'h00;
			en_q <= 8'h00;
			sel_q <= 8'h00;
			fmt_q <= 8'h00;
		end else if (ce_in) begin
			if (we_dur_w) dur_q <= byte_w;
			if (we_axis_w) axis_q <= byte_w;
			if (we_rate_w) rate_q <= byte_w & MASK_RATE;
			if (we_pwr_w) power_q <= byte_w & MASK_POWER;
			if (we_en_w) en_q <= byte_w & MASK_IRQ;
			if (we_sel_w) sel_q <= byte_w & MASK_IRQ;
			if (we_fmt_w) fmt_q <= byte_w & MASK_FORMAT;
		end
	end

	// mode decode
	wire logic measure_w = power_q[BIT_MEASURE];
	wire logic sleep_w = power_q[BIT_SLEEP] | doze_q;
	wire logic act_on_w = |axis_q[BIT_ACT_X -: 3];
	wire logic q_on_w = |axis_q[BIT_QUIET_X -: 3];
	wire logic link_w = power_q[BIT_LINK];
	wire logic link_both_w = link_w && act_on_w && q_on_w;
	wire logic act_run_w = measure_w && act_on_w
		&& (!link_both_w || st_q == LINK_SEEK_MOTION);
	// quiet waits for the motion flag to be cleared in linked mode
	wire logic q_run_w = measure_w && q_on_w && !sleep_w
		&& (!link_both_w || (st_q == LINK_SEEK_QUIET
		&& !flags_q[BIT_ACT]));
	wire logic act_ac_w = axis_q[BIT_ACT_AC];
	wire logic q_ac_w = axis_q[BIT_QUIET_AC];
	wire logic [17:0] act_lim_w = {6'h00, motion_threshold_in, 4'h0};
	wire logic [17:0] q_lim_w = {6'h00, quiet_threshold_in, 4'h0};
	wire logic aref_load_w = sample_valid_in && act_run_w && !aref_ok_q;
	wire logic q_noisy_w = |q_hit_w;
	wire logic qref_load_w = sample_valid_in && q_run_w
		&& (!qref_ok_q || q_noisy_w);

	for (genvar i = 0; i < 3; i++) begin : g_axis
		logic [15:0] aref_q, qref_q;
		wire logic signed [17:0] cur_w = 18'($signed(sample_in.axis[i]));
		wire logic signed [17:0] adif_w = act_ac_w
			? cur_w - 18'($signed(aref_q)) : cur_w;
		wire logic signed [17:0] qdif_w = q_ac_w
			? cur_w - 18'($signed(qref_q)) : cur_w;
		wire logic [17:0] amag_w = adif_w[17] ? 18'(-adif_w) : adif_w;
		wire logic [17:0] qmag_w = qdif_w[17] ? 18'(-qdif_w) : qdif_w;
		assign act_hit_w[i] = axis_q[BIT_ACT_X - i]
			&& (amag_w > act_lim_w);
		assign q_hit_w[i] = axis_q[BIT_QUIET_X - i]
			&& (qmag_w >= q_lim_w);
		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				aref_q <= 16'h0000;
				qref_q <= 16'h0000;
			end else if (ce_in) begin
				if (aref_load_w) aref_q <= sample_in.axis[i];
				if (qref_load_w) qref_q <= sample_in.axis[i];
			end
		end
	end

	wire logic act_ready_w = !act_ac_w || aref_ok_q;
	wire logic q_ready_w = !q_ac_w || qref_ok_q;
	wire logic act_ev_w = sample_valid_in && act_run_w && act_ready_w
		&& (|act_hit_w);
	wire logic q_good_w = sample_valid_in && q_run_w && q_ready_w
		&& !q_noisy_w;
	wire logic q_ev_w = q_good_w && (secs_q >= dur_q)
		&& !q_fired_q;
	wire logic q_reset_w = !q_run_w
		|| (sample_valid_in && (q_noisy_w || !q_ready_w));
	wire logic sec_wrap_w = tick_q == 32'(CYC_PER_SEC - 1);

	// quiet timing counts whole seconds from the first quiet sample
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			aref_ok_q <= 1'b0;
			qref_ok_q <= 1'b0;
			q_arm_q <= 1'b0;
			q_fired_q <= 1'b0;
			tick_q <= 32'h0;
			secs_q <= 8'h00;
		end else if (ce_in) begin
			aref_ok_q <= act_run_w && (aref_ok_q || aref_load_w);
			qref_ok_q <= q_run_w && (qref_ok_q || qref_load_w);
			if (q_reset_w) begin
				q_arm_q <= 1'b0;
				q_fired_q <= 1'b0;
				tick_q <= 32'h0;
				secs_q <= 8'h00;
			end else begin
				if (q_good_w) q_arm_q <= 1'b1;
				if (q_ev_w) q_fired_q <= 1'b1;
				if (q_arm_q) begin
					tick_q <= sec_wrap_w ? 32'h0 : 32'(tick_q + 32'h1);
					if (sec_wrap_w && secs_q != 8'hff)
						secs_q <= 8'(secs_q + 8'h01);
				end
			end
		end
	end

	// linked sequencing and automatic sleep
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_q <= LINK_SEEK_QUIET;
			doze_q <= 1'b0;
		end else if (ce_in) begin
			if (!link_both_w)
				st_q <= LINK_SEEK_QUIET;
			else if (q_ev_w)
				st_q <= LINK_SEEK_MOTION;
			else if (act_ev_w)
				st_q <= LINK_SEEK_QUIET;
			if (!link_w || !power_q[BIT_AUTO] || !measure_w || act_ev_w)
				doze_q <= 1'b0;
			else if (q_ev_w)
				doze_q <= 1'b1;
		end
	end

	// flags: set beats clear in the same cycle
	wire logic [7:0] flag_set_w = {dready_event_in && !sleep_w, 2'b00,
		act_ev_w, q_ev_w, 1'b0, watermark_event_in,
		overrun_event_in};
	wire logic [7:0] flag_clr_w = (data_rd_w ? MASK_FIFO_FLAG : 8'h00)
		| (flag_rd_w ? (rpt_q & MASK_MOT_FLAG) : 8'h00);
	wire logic [7:0] pend_w = flags_q & en_q;
	wire logic inv_w = fmt_q[BIT_INVERT];

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			flags_q <= RST_FLAGS;
			irq_a_q <= 1'b0;
			irq_b_q <= 1'b0;
			data_q <= '0;
			fifo_wr_q <= 1'b0;
			sleep_q <= 1'b0;
			data_rd_q <= 1'b0;
		end else if (ce_in) begin
			flags_q <= (flags_q & ~flag_clr_w) | flag_set_w;
			irq_a_q <= (|(pend_w & ~sel_q)) ^ inv_w;
			irq_b_q <= (|(pend_w & sel_q)) ^ inv_w;
			if (sample_valid_in && measure_w && !sleep_w)
				data_q <= sample_in;
			fifo_wr_q <= measure_w && !sleep_w;
			sleep_q <= sleep_w;
			data_rd_q <= data_rd_w;
		end
	end

	assign spi_sdo_out = sdo_q;
	assign spi_sdo_oe_n_out = oe_n_q;
	assign irq_line_a_out = irq_a_q;
	assign irq_line_b_out = irq_b_q;
	assign measure_out = power_q[BIT_MEASURE];
	assign sleep_out = sleep_q;
	assign fifo_write_en_out = fifo_wr_q;
	assign data_read_out = data_rd_q;
	assign low_power_out = rate_q[BIT_LOWPWR];
	assign sample_rate_out = rate_q[3:0];
	assign doze_reading_rate_out = power_q[1:0];
	assign self_test_out = fmt_q[BIT_SELFTEST];
	assign three_wire_out = fmt_q[BIT_3WIRE];
	assign scaled_resolution_mode_out = fmt_q[BIT_FULLRES];
	assign justify_out = fmt_q[BIT_JUSTIFY];
	assign range_out = fmt_q[1:0];

	default clocking cb @(posedge clk_in iff ce_in); endclocking
	default disable iff (rst_in);

	sequence s_quiet_fire;
		q_ev_w && link_w && power_q[BIT_AUTO] && !act_ev_w;
	endsequence
	property p_auto_sleep;
		s_quiet_fire ##1 1'b1 |=> sleep_q;
	endproperty
	a_auto_sleep: assert property (p_auto_sleep)
		else $error("auto sleep not entered after quiet");
	property p_standby_no_fifo;
		!measure_w ##1 !measure_w |-> !fifo_write_en_out;
	endproperty
	a_standby_no_fifo: assert property (p_standby_no_fifo)
		else $error("fifo written in standby");
	property p_sleep_blocks_dready;
		(sleep_w && !flags_q[BIT_DREADY]) |=> !flags_q[BIT_DREADY];
	endproperty
	a_sleep_blocks_dready: assert property (p_sleep_blocks_dready)
		else $error("data ready flagged in sleep");
	property p_set_wins;
		(watermark_event_in && data_rd_w) |=> flags_q[BIT_WMARK];
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("watermark event lost on clear");
	property p_flag_read_clears;
		(flag_rd_w && rpt_q[BIT_ACT] && !act_ev_w) |=> !flags_q[BIT_ACT];
	endproperty
	a_flag_read_clears: assert property (p_flag_read_clears)
		else $error("motion flag kept after flag read");
	property p_masked_quiet;
		(en_q == 8'h00 && !inv_w) [*2] |=> !irq_line_a_out && !irq_line_b_out;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet)
		else $error("interrupt with all enables off");
	property p_route_b;
		(pend_w[BIT_ACT] && sel_q[BIT_ACT] && !inv_w) |=> irq_line_b_out;
	endproperty
	a_route_b: assert property (p_route_b)
		else $error("motion not routed to line b");
	property p_link_order;
		(link_both_w && st_q == LINK_SEEK_QUIET) |-> !act_ev_w;
	endproperty
	a_link_order: assert property (p_link_order)
		else $error("motion seen while seeking quiet");
	property p_no_axes;
		(axis_q[BIT_ACT_X -: 3] == 3'h0) |-> !act_ev_w;
	endproperty
	a_no_axes: assert property (p_no_axes)
		else $error("motion event with no axis enabled");
	property p_fixed_zero;
		rate_q[7:5] == 3'h0 && power_q[7:6] == 2'h0;
	endproperty
	a_fixed_zero: assert property (p_fixed_zero)
		else $error("fixed zero field set");
	property p_quiet_timing;
		q_ev_w |-> sample_valid_in && secs_q >= dur_q && !q_noisy_w;
	endproperty
	a_quiet_timing: assert property (p_quiet_timing)
		else $error("quiet event without timing met");
endmodule
`default_nettype wire

// ---- mdipc_host.sv ----
/*
 Host side SPI master model for the mdipc bench: mode 3, 80 ns sclk.
 Assumes a 100 MHz bench clock on clk_in.
*/
`timescale 1ns/1ns
`default_nettype none
module mdipc_host (
	input  wire logic       clk_in,     // bench clock
	input  wire logic       sdo_in,     // data from device
	output logic            cs_n_out,   // chip select, low
	output logic            sclk_out,   // serial clock
	output logic            sdi_out,    // data to device
	output logic [7:0]      rd_out,     // byte just read
	output logic            rd_stb_out  // pulse per read byte
);
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b1;
		sdi_out = 1'b0;
		rd_stb_out = 1'b0;
	end
	task automatic half();
		repeat (4) @(posedge clk_in);
		#1;
	endtask
	// data moves while sclk is low, so it is steady at each rising edge
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd);
		logic [15:0] sh;
		sh = {cmd, wd};
		cs_n_out = 1'b0;
		half();
		for (int i = 0; i < 16; i++) begin
			sclk_out = 1'b0;
			sdi_out = sh[15];
			half();
			sclk_out = 1'b1;
			sh = {sh[14:0], sdo_in};
			half();
		end
		cs_n_out = 1'b1;
		// a released line must not keep its last level
		sdi_out = ~sdi_out;
		rd_out = sh[7:0];
		rd_stb_out = cmd[7];
		half();
		rd_stb_out = 1'b0;
		half();
	endtask
endmodule
`default_nettype wire

// ---- mdipc_top_test.sv ----
/*
 Self-checking bench of mdipc_top, driven through the SPI host model.
 Assumes the quiet time unit is shortened to 100 clocks.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %0t: got %h want %h", $time, a, e); end end
module mdipc_top_test;
	import mdipc_pkg::*;
	logic clk_in, rst_in, spi_cs_n_in, spi_sclk_in, spi_sdi_in, spi_sdio_in;
	logic spi_sdo_out, spi_sdo_oe_n_out, sample_valid_in, dready_event_in;
	logic watermark_event_in, overrun_event_in, irq_line_a_out;
	logic irq_line_b_out, measure_out, sleep_out, fifo_write_en_out;
	logic data_read_out, low_power_out, self_test_out, three_wire_out;
	logic scaled_resolution_mode_out, justify_out, rd_stb;
	logic [1:0] doze_reading_rate_out, range_out;
	logic [3:0] sample_rate_out;
	logic [7:0] motion_threshold_in, quiet_threshold_in, rd, v, exp_v;
	logic [31:0] seed;
	mdipc_sample_type sample_in;
	logic [7:0] exp_q[$];
	int checks, error_cnt, n, dread_cnt;
	// id value is arbitrary
	mdipc_top #(.CYC_PER_SEC(100), .DEV_ID(8'h3c)) i_dut (.clk_in, .rst_in,
		.ce_in(1'b1), .spi_cs_n_in, .spi_sclk_in, .spi_sdi_in, .spi_sdio_in,
		.spi_sdo_out, .spi_sdo_oe_n_out, .sample_valid_in, .sample_in,
		.motion_threshold_in, .quiet_threshold_in, .dready_event_in,
		.watermark_event_in, .overrun_event_in, .irq_line_a_out,
		.irq_line_b_out, .measure_out, .sleep_out, .fifo_write_en_out,
		.data_read_out, .low_power_out, .sample_rate_out,
		.doze_reading_rate_out, .self_test_out, .three_wire_out,
		.scaled_resolution_mode_out, .justify_out, .range_out);
	mdipc_host i_host (.clk_in, .sdo_in(spi_sdo_out), .cs_n_out(spi_cs_n_in),
		.sclk_out(spi_sclk_in), .sdi_out(spi_sdi_in), .rd_out(rd),
		.rd_stb_out(rd_stb));
	// shared data pin in 3-wire mode: device wins while it drives
	assign spi_sdio_in = spi_sdo_oe_n_out ? spi_sdi_in : spi_sdo_out;
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	// pop once: the macro names its expected value twice
	always @(posedge rd_stb) begin
		exp_v = exp_q.pop_front();
		`CHK(rd, exp_v)
	end
	always @(negedge clk_in) begin
		if (data_read_out === 1'b1)
			dread_cnt++;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic tick(input int c);
		repeat (c) @(posedge clk_in);
		#1;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		i_host.xfer({2'b00, a}, d);
	endtask
	task automatic rd_exp(input logic [5:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.xfer({2'b10, a}, 8'h00);
	endtask
	task automatic put(input logic [15:0] x, input logic [15:0] y);
		sample_in.axis[0] = x;
		sample_in.axis[1] = y;
		sample_valid_in = 1'b1;
		tick(1);
		sample_valid_in = 1'b0;
		tick(9);
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk_in);
		error_cnt++;
		conclude();
	end
	initial begin
		{sample_valid_in, dready_event_in, watermark_event_in} = 3'h0;
		overrun_event_in = 1'b0;
		sample_in = '0;
		motion_threshold_in = 8'h02;
		quiet_threshold_in = 8'h01;
		seed = 32'hc15127a3;
		rst_in = 1'b1;
		tick(5);
		rst_in = 1'b0;
		tick(3);
		rd_exp(ADDR_RATE, RST_RATE);
		rd_exp(ADDR_POWER, 8'h00);
		rd_exp(ADDR_ID, 8'h3c);
		rd_exp(ADDR_FLAGS, RST_FLAGS);
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			v = seed[7:0];
			wr(ADDR_RATE, v);
			rd_exp(ADDR_RATE, v & MASK_RATE);
			wr(ADDR_FORMAT, v);
			rd_exp(ADDR_FORMAT, v & MASK_FORMAT);
			wr(ADDR_POWER, {6'h00, v[1:0]});
			wr(ADDR_IRQ_EN, v);
			rd_exp(ADDR_IRQ_EN, v & MASK_IRQ);
			`CHK({low_power_out, sample_rate_out}, v[4:0])
			`CHK(doze_reading_rate_out, v[1:0])
			`CHK({self_test_out, three_wire_out}, v[7:6])
			`CHK({scaled_resolution_mode_out, justify_out}, v[3:2])
			`CHK(range_out, v[1:0])
		end
		wr(ADDR_FORMAT, 8'h00);
		wr(ADDR_IRQ_EN, 8'h01);
		wr(ADDR_IRQ_SEL, 8'h01);
		overrun_event_in = 1'b1;
		tick(1);
		overrun_event_in = 1'b0;
		tick(3);
		`CHK({irq_line_a_out, irq_line_b_out}, 2'b01)
		rd_exp(ADDR_DATA_LO, 8'h00);
		`CHK(irq_line_b_out, 1'b0)
		`CHK(dread_cnt, 1)
		`CHK(spi_sdo_oe_n_out, 1'b1)
		dready_event_in = 1'b1;
		tick(1);
		dready_event_in = 1'b0;
		tick(3);
		`CHK({irq_line_a_out, irq_line_b_out}, 2'b00)
		rd_exp(ADDR_FLAGS, 8'h80);
		wr(ADDR_FORMAT, 8'h20);
		`CHK({irq_line_a_out, irq_line_b_out}, 2'b11)
		wr(ADDR_FORMAT, 8'h00);
		wr(ADDR_IRQ_EN, 8'h10);
		wr(ADDR_IRQ_SEL, 8'h00);
		wr(ADDR_AXIS_CTL, 8'h40);
		wr(ADDR_POWER, 8'h08);
		`CHK(measure_out, 1'b1)
		put(16'd0, 16'd100);
		put(16'd32, 16'd0);
		`CHK(irq_line_a_out, 1'b0)
		put(16'd33, 16'd0);
		`CHK(irq_line_a_out, 1'b1)
		rd_exp(ADDR_FLAGS, 8'h90);
		`CHK(irq_line_a_out, 1'b0)
		wr(ADDR_AXIS_CTL, 8'h77);
		wr(ADDR_QUIET_DUR, 8'h01);
		wr(ADDR_POWER, 8'h38);
		for (n = 0; n < 40 && sleep_out !== 1'b1; n++)
			put(16'd5, 16'd5);
		`CHK(sleep_out, 1'b1)
		`CHK(fifo_write_en_out, 1'b0)
		rd_exp(ADDR_FLAGS, 8'h88);
		wr(ADDR_POWER, 8'h00);
		wr(ADDR_POWER, 8'h08);
		`CHK({sleep_out, fifo_write_en_out}, 2'b01)
		wr(ADDR_IRQ_SEL, 8'h10);
		wr(ADDR_AXIS_CTL, 8'hc0);
		put(16'd100, 16'd0);
		put(16'd130, 16'd0);
		`CHK({irq_line_a_out, irq_line_b_out}, 2'b00)
		put(16'd133, 16'd0);
		`CHK({irq_line_a_out, irq_line_b_out}, 2'b01)
		rd_exp(ADDR_FLAGS, 8'h90);
		wr(ADDR_AXIS_CTL, 8'h0c);
		wr(ADDR_IRQ_EN, 8'h08);
		for (n = 0; n < 40 && irq_line_a_out !== 1'b1; n++)
			put(16'd110, 16'd0);
		`CHK(irq_line_a_out, 1'b1)
		rd_exp(ADDR_FLAGS, 8'h88);
		// watermark held across the data read: set must beat clear
		watermark_event_in = 1'b1;
		rd_exp(ADDR_DATA_LO, 8'h6e);
		watermark_event_in = 1'b0;
		`CHK(dread_cnt, 2)
		rd_exp(ADDR_FLAGS, 8'h02);
		`CHK(spi_sdo_oe_n_out, 1'b1)
		tick(20);
		conclude();
	end
endmodule
`default_nettype wire
